/* verilog/ring_anim_pkg.sv */
// Package with register map, field layout and reset values of the ring animator
package ring_anim_pkg;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_PATTERN_FIRST = 4'h4;
  localparam logic [3:0] ADDR_PATTERN_SECOND = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam int CTL_FC_EN_BIT = 0;
  localparam int CTL_ANIM_EN_BIT = 1;
  localparam int CTL_FUNC_OR_BIT = 2;
  localparam int CTL_DIR_FIRST_BIT = 3;
  localparam int CTL_DIR_SECOND_BIT = 4;
  localparam int CTL_LOC_BIT = 5;
  localparam int CTL_TOP_LSB = 8;
  localparam int TOP_WIDTH = 6;
  localparam int RING_WIDTH = 8;
  localparam int SEG_WIDTH = 16;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    DIR_LEFT = 2'b00,
    DIR_RIGHT = 2'b01
  } dir_t;
endpackage

/* verilog/pattern_bus_if.sv */
// Interface carrying one pattern register's load and step controls
`timescale 1ns/10ps
interface pattern_bus_if;
  logic load;
  logic [7:0] load_data;
  logic step;
  logic dir_right;
  logic [7:0] value;
  modport ctrl (output load, output load_data, output step, output dir_right, input value);
  modport pat (input load, input load_data, input step, input dir_right, output value);
endinterface

/* verilog/pattern_rotator.sv */
// One rotating animation pattern register
`timescale 1ns/10ps
module pattern_rotator (
  input wire logic aclk,
  input wire logic aresetn,
  pattern_bus_if.pat bus
);
  import ring_anim_pkg::*;
  logic [7:0] pattern_reg;
  logic [7:0] pattern_next;
  wire [7:0] rot_left = {pattern_reg[6:0], pattern_reg[7]}; // [RULE_11]
  wire [7:0] rot_right = {pattern_reg[0], pattern_reg[7:1]}; // [RULE_11]
  // Software load wins over a step in the same cycle
  assign pattern_next = bus.load ? bus.load_data : // [RULE_10]
                        bus.step ? (bus.dir_right ? rot_right : rot_left) : pattern_reg; // [RULE_03] [RULE_04]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pattern_reg <= PATTERN_RESET;
    end else begin
      pattern_reg <= pattern_next;
    end
  end
  assign bus.value = pattern_reg;
endmodule // pattern_rotator

/* verilog/ring_animator.sv */
// Segment LCD ring animation engine with AXI4-Lite register slave
`timescale 1ns/10ps
// Function
// RULE_01 - Drive eight-segment ring autonomously after setup
// RULE_02 - Segment value is AND/OR of patterns
// RULE_03 - Rotate both patterns on frame overflow
// RULE_04 - Each pattern has own direction bit
// RULE_05 - Overflow period set by top field
// RULE_06 - Frame counter advances only when enabled
// RULE_07 - Segments driven only when animation enabled
// RULE_08 - Control bit selects AND or OR
// RULE_09 - Location bit selects segments 0-7 or 8-15
// RULE_10 - Software writes load new pattern start
// RULE_11 - Rotated-out bit re-enters opposite end
// RULE_12 - Counter restarts at zero after top
module ring_animator (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_tick,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [ring_anim_pkg::SEG_WIDTH-1:0] anim_segments
);
  import ring_anim_pkg::*;

  logic [31:0] control_reg;
  logic [TOP_WIDTH-1:0] frame_count_reg;
  logic overflow_reg;
  logic frame_sync1_reg;
  logic frame_sync2_reg;
  logic frame_prev_reg;
  logic [3:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic [SEG_WIDTH-1:0] seg_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  pattern_bus_if first_bus ();
  pattern_bus_if second_bus ();

  // Control field decode
  wire fc_enable = control_reg[CTL_FC_EN_BIT];
  wire anim_enable = control_reg[CTL_ANIM_EN_BIT];
  wire func_or = control_reg[CTL_FUNC_OR_BIT];
  wire dir_first = control_reg[CTL_DIR_FIRST_BIT];
  wire dir_second = control_reg[CTL_DIR_SECOND_BIT];
  wire upper_segment_group = control_reg[CTL_LOC_BIT];
  wire [TOP_WIDTH-1:0] frame_counter_top = control_reg[CTL_TOP_LSB +: TOP_WIDTH];

  // Frame edge from the LCD frame timing, synchronised first
  wire frame_edge = frame_sync2_reg & ~frame_prev_reg;
  wire at_top = (frame_count_reg == frame_counter_top);
  wire frame_step = fc_enable & frame_edge; // [RULE_06]
  wire overflow = frame_step & at_top; // [RULE_05]
  wire [TOP_WIDTH-1:0] count_next = !fc_enable ? frame_count_reg :
                                    !frame_edge ? frame_count_reg :
                                    at_top ? '0 : frame_count_reg + 1'b1; // [RULE_12]

  // Register write path
  wire aw_have = aw_held_reg | s_axi_awvalid;
  wire w_have = w_held_reg | s_axi_wvalid;
  wire [3:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  // Commit only once both channels are held, at the edge that raises bvalid
  wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire wr_ctrl = wr_fire & (wr_addr == ADDR_CONTROL);
  wire wr_first = wr_fire & (wr_addr == ADDR_PATTERN_FIRST) & wr_strb[0];
  wire wr_second = wr_fire & (wr_addr == ADDR_PATTERN_SECOND) & wr_strb[0];
  wire wr_known = (wr_addr == ADDR_CONTROL) | (wr_addr == ADDR_PATTERN_FIRST) | (wr_addr == ADDR_PATTERN_SECOND);
  wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] control_next = wr_ctrl ? ((control_reg & ~strb_mask) | (wr_data & strb_mask)) : control_reg;

  // Register read path
  wire rd_fire = s_axi_arvalid & arready_reg;
  wire [31:0] status_word = {22'h000000, 2'h0, overflow_reg, 1'b0, frame_count_reg};
  wire rd_known = (s_axi_araddr == ADDR_CONTROL) | (s_axi_araddr == ADDR_PATTERN_FIRST) |
                  (s_axi_araddr == ADDR_PATTERN_SECOND) | (s_axi_araddr == ADDR_STATUS);
  wire [31:0] rd_word = (s_axi_araddr == ADDR_CONTROL) ? control_reg :
                        (s_axi_araddr == ADDR_PATTERN_FIRST) ? {24'h000000, first_bus.value} :
                        (s_axi_araddr == ADDR_PATTERN_SECOND) ? {24'h000000, second_bus.value} :
                        (s_axi_araddr == ADDR_STATUS) ? status_word : 32'h0000_0000;

  // Pattern register control
  assign first_bus.load = wr_first; // [RULE_10]
  assign first_bus.load_data = wr_data[7:0];
  assign first_bus.step = overflow; // [RULE_03]
  assign first_bus.dir_right = dir_first; // [RULE_04]
  assign second_bus.load = wr_second; // [RULE_10]
  assign second_bus.load_data = wr_data[7:0];
  assign second_bus.step = overflow; // [RULE_03]
  assign second_bus.dir_right = dir_second; // [RULE_04]

  pattern_rotator u_first (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(first_bus)
  );
  pattern_rotator u_second (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(second_bus)
  );

  // Segment output
  wire [RING_WIDTH-1:0] ring_and = first_bus.value & second_bus.value;
  wire [RING_WIDTH-1:0] ring_or = first_bus.value | second_bus.value;
  wire [RING_WIDTH-1:0] ring = func_or ? ring_or : ring_and; // [RULE_02] [RULE_08]
  wire [RING_WIDTH-1:0] ring_gated = anim_enable ? ring : '0; // [RULE_07]
  wire [SEG_WIDTH-1:0] seg_next = upper_segment_group ? {ring_gated, 8'h00} : {8'h00, ring_gated}; // [RULE_09]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_sync1_reg <= 1'b0;
      frame_sync2_reg <= 1'b0;
      frame_prev_reg <= 1'b0;
      frame_count_reg <= '0;
      overflow_reg <= 1'b0;
      seg_reg <= '0;
    end else begin
      frame_sync1_reg <= frame_tick;
      frame_sync2_reg <= frame_sync1_reg;
      frame_prev_reg <= frame_sync2_reg;
      frame_count_reg <= count_next; // [RULE_06]
      overflow_reg <= overflow;
      seg_reg <= seg_next; // [RULE_01]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= CONTROL_RESET;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      control_reg <= control_next;
      awready_reg <= ~aw_held_reg & ~bvalid_reg;
      wready_reg <= ~w_held_reg & ~bvalid_reg;
      if (s_axi_awvalid & awready_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid & wready_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      if (aw_held_reg & w_held_reg & ~bvalid_reg) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg & s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_reg & ~arready_reg & s_axi_arvalid;
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign anim_segments = seg_reg;
endmodule // ring_animator

/* bench/ring_anim_props.sv */
// Port checker for the ring animator
`timescale 1ns/10ps
module ring_anim_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] anim_segments
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  one_group_a: assert property (anim_segments[15:8] == 8'h00 || anim_segments[7:0] == 8'h00)
    else $error("both segment groups driven");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read ready not a pulse");
  rvalid_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule // ring_anim_props

/* bench/lcd_drv.sv */
// Model of the LCD segment drivers, source of frame timing
`timescale 1ns/10ps
module lcd_drv (
  input wire logic aclk,
  output logic frame_tick
);
  initial frame_tick = 1'b0;
  // One frame, each phase held gap cycles
  task automatic frame(input int gap);
    frame_tick <= 1'b1;
    repeat (gap) @(posedge aclk);
    frame_tick <= 1'b0;
    repeat (gap) @(posedge aclk);
  endtask
endmodule // lcd_drv

/* bench/tb_top.sv */
// Self-checking testbench for the ring animator
`timescale 1ns/10ps
module tb_top;
  import ring_anim_pkg::*;
  logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, frame_tick;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, ctl;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] anim_segments;
  logic [7:0] pa, pb;
  int mismatches = 0, samples_checked = 0, top;
  ring_animator u_ring_animator (.aclk, .aresetn, .frame_tick, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .anim_segments);
  lcd_drv u_lcd_drv (.aclk, .frame_tick);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic end_sim;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      mismatches++;
      $display("wrong value at %0t: bus wait timed out", $time);
      end_sim();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && (s_axi_awvalid || s_axi_wvalid); n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    tmo(n);
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) @(posedge aclk);
    tmo(n);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, RESP_OKAY);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && s_axi_arready !== 1'b1; n++) @(posedge aclk);
    tmo(n);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) @(posedge aclk);
    tmo(n);
    d = s_axi_rdata;
    chk(s_axi_rresp, RESP_OKAY);
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [7:0] rot(input logic [7:0] v, input logic r);
    return r ? {v[0], v[7:1]} : {v[6:0], v[7]};
  endfunction
  function automatic logic [15:0] seg(input logic [7:0] a, input logic [7:0] b, input logic [31:0] c);
    logic [7:0] s;
    s = c[CTL_FUNC_OR_BIT] ? (a | b) : (a & b);
    if (c[CTL_ANIM_EN_BIT] !== 1'b1) s = 8'h00;
    return c[CTL_LOC_BIT] ? {s, 8'h00} : {8'h00, s};
  endfunction
  initial begin
    void'($urandom(50));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CONTROL, rdv);
    chk(rdv, CONTROL_RESET);
    for (int i = 0; i < 12; i++) begin
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      pa = 8'($urandom);
      pb = 8'($urandom);
      top = (i == 0) ? 0 : (i == 1) ? 63 : $urandom_range(4);
      ctl = {18'h0, 6'(top), (8'($urandom) & 8'h3C) | 8'h03};
      if (i == 2) ctl[CTL_ANIM_EN_BIT] = 1'b0;
      if (i == 3) ctl[CTL_FC_EN_BIT] = 1'b0;
      chk(anim_segments, 16'h0000);
      wr(ADDR_PATTERN_FIRST, {24'h0, pa});
      wr(ADDR_PATTERN_SECOND, {24'h0, pb});
      wr(ADDR_CONTROL, ctl);
      repeat (top) u_lcd_drv.frame(2 + i % 3);
      repeat (4) @(posedge aclk);
      chk(anim_segments, seg(pa, pb, ctl));
      rd(ADDR_STATUS, rdv);
      chk(rdv[5:0], ctl[CTL_FC_EN_BIT] ? top : 0);
      u_lcd_drv.frame(2);
      repeat (4) @(posedge aclk);
      if (ctl[CTL_FC_EN_BIT]) begin
        pa = rot(pa, ctl[CTL_DIR_FIRST_BIT]);
        pb = rot(pb, ctl[CTL_DIR_SECOND_BIT]);
      end
      chk(anim_segments, seg(pa, pb, ctl));
      rd(ADDR_STATUS, rdv);
      chk(rdv[5:0], 0);
    end
    end_sim();
  end
endmodule // tb_top
bind ring_animator ring_anim_props u_ring_anim_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .anim_segments);
